// *** include/fsr_pkg.sv ***
// fsr_pkg: shared widths, state layout and burst arithmetic of the sram input stage
// assumes: one clock domain, all pins synchronous to it
package fsr_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADDR_W = 21;
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int BURST_W = 2;
    localparam int WORD_W = DATA_W + PAR_W;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SEED_LSB = 0;
    localparam int UPPER_LSB = BURST_W;
    localparam int PAR_LSB = DATA_W;

    // ************************************************************
    // control state
    // ************************************************************
    typedef struct packed {
        logic active;
        logic isWrite;
        logic [ADDR_W-1:0] base;
        logic [BURST_W-1:0] seed;
        logic [BURST_W-1:0] beat;
        logic wrPend;
        logic [ADDR_W-1:0] wrAddr;
        logic [LANES-1:0] wrLanes;
        logic drive;
    } fsr_state_s;

    localparam fsr_state_s STATE_RST = '0;
    localparam logic [BURST_W-1:0] BEAT_RST = 2'h0;
    localparam logic [WORD_W-1:0] RDATA_RST = 36'h0;

    // low address bits for a given beat, linear or interleaved order
    function automatic logic [BURST_W-1:0] fsrBurstLow(
        input logic [BURST_W-1:0] seed,
        input logic [BURST_W-1:0] beat,
        input logic linear
    );
        fsrBurstLow = linear ? BURST_W'(seed + beat) : (seed ^ beat);
    endfunction

    // full address of a beat inside the burst
    function automatic logic [ADDR_W-1:0] fsrBeatAddr(
        input logic [ADDR_W-1:0] base,
        input logic [BURST_W-1:0] seed,
        input logic [BURST_W-1:0] beat,
        input logic linear
    );
        fsrBeatAddr = {base[ADDR_W-1:UPPER_LSB], fsrBurstLow(seed, beat, linear)};
    endfunction

endpackage

// *** include/fsr_mem_if.sv ***
// fsr_mem_if: write and read port between the input stage and its storage array
// assumes: both ends clocked by the same clk
`timescale 1ns/10ps
interface fsr_mem_if;
    import fsr_pkg::*;
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [WORD_W-1:0] wrData;
    logic [LANES-1:0] wrMask;
    logic rdEn;
    logic [ADDR_W-1:0] rdAddr;
    logic [WORD_W-1:0] rdData;

    modport ctrl (output wrEn, wrAddr, wrData, wrMask, rdEn, rdAddr, input rdData);
    modport mem (input wrEn, wrAddr, wrData, wrMask, rdEn, rdAddr, output rdData);
endinterface

// *** design/fsr_mem.sv ***
// fsr_mem: storage array with byte-lane write mask and registered read data
// assumes: read and write of the same word in one edge returns the old word
`timescale 1ns/10ps
module fsr_mem
    import fsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // port to the controller
    fsr_mem_if.mem port
);

    logic [WORD_W-1:0] store [0:(1<<ADDR_W)-1];
    logic [WORD_W-1:0] rdData_q;

    // ************************************************************
    // array write, one lane is 8 data bits plus its parity bit
    // ************************************************************
    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            for (int i = 0; i < LANES; i++) begin
                if (port.wrMask[i]) begin
                    store[port.wrAddr][i*LANE_W +: LANE_W] <= port.wrData[i*LANE_W +: LANE_W];
                    store[port.wrAddr][PAR_LSB+i] <= port.wrData[PAR_LSB+i];
                end
            end
        end
    end

    // read data held while no read is issued, so a stall keeps the bus steady
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_q <= RDATA_RST;
        end else if (port.rdEn) begin
            rdData_q <= store[port.rdAddr];
        end
    end

    assign port.rdData = rdData_q;

endmodule

// *** design/fsr_core.sv ***
// fsr_core: synchronous input stage of a flow-through burst sram
// assumes: pins synchronous to clk, driven by a memory controller; the bench resolves dq lines
//
// Function
// - register address at a recognised edge and select the word accessed.
// - load the low two address bits into the two-bit burst counter.
// - byte-lane writes take effect only together with the write strobe.
// - write strobe is sampled only at edges with clock qualifier low.
// - advance input high at a recognised edge steps the burst counter of an open burst.
// - advance input low at a recognised edge loads a new address.
// - inputs are captured only at edges with the clock qualifier low.
// - qualifier high stretches the cycle, state and output data unchanged.
// - selected only when first and third selects low, second high.
// - read data flows out in the cycle after its address edge.
// - data and parity released on write data, after deselect, and while deselected.
`timescale 1ns/10ps
module fsr_core
    import fsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // address and burst control
    input wire logic [ADDR_W-1:0] addr,
    input wire logic loadOrAdvance,
    input wire logic clockQualifierN,
    input wire logic burstLinear,
    // write control
    input wire logic writeStrobeN,
    input wire logic [LANES-1:0] byteLaneWriteN,
    // selects and output enable
    input wire logic selectLowFirstN,
    input wire logic selectHighSecond,
    input wire logic selectLowThirdN,
    input wire logic outputEnableN,
    // data lines
    input wire logic [DATA_W-1:0] dqIn,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    // parity lines
    input wire logic [PAR_W-1:0] parityLinesIn,
    output logic [PAR_W-1:0] parityLinesOut,
    output logic parityLinesOe
);

    fsr_state_s s_q;
    fsr_state_s s_d;
    fsr_mem_if memIf();

    logic rec;
    logic sel;
    logic [BURST_W-1:0] nextBeat;

    fsr_mem u_mem (
        .clk(clk),
        .rst(rst),
        .port(memIf.mem)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        rec = !clockQualifierN;
        sel = !selectLowFirstN && selectHighSecond && !selectLowThirdN;
        nextBeat = BURST_W'(s_q.beat + 2'h1);
        memIf.wrEn = 1'b0;
        memIf.wrAddr = s_q.wrAddr;
        memIf.wrData = {parityLinesIn, dqIn};
        memIf.wrMask = s_q.wrLanes;
        memIf.rdEn = 1'b0;
        memIf.rdAddr = addr;
        // qualifier high: nothing moves, the previous cycle is stretched
        if (rec) begin
            // write data belongs to the next recognised edge after its address
            memIf.wrEn = s_q.wrPend;
            s_d.wrPend = 1'b0;
            if (!loadOrAdvance) begin
                s_d.active = sel;
                s_d.isWrite = !writeStrobeN;
                s_d.base = addr;
                s_d.seed = addr[SEED_LSB +: BURST_W];
                s_d.beat = BEAT_RST;
                memIf.rdAddr = addr;
            end else begin
                // a burst with nothing open stays idle; the far side loads instead
                s_d.beat = s_q.active ? nextBeat : s_q.beat;
                memIf.rdAddr = fsrBeatAddr(s_q.base, s_q.seed, nextBeat, burstLinear);
            end
            memIf.rdEn = s_d.active && !s_d.isWrite;
            if (s_d.active && s_d.isWrite) begin
                s_d.wrPend = 1'b1;
                s_d.wrAddr = memIf.rdAddr;
                s_d.wrLanes = ~byteLaneWriteN;
            end
            // released for write data, first cycle out of deselect, and while deselected
            s_d.drive = s_d.active && !s_d.isWrite && s_q.active && !outputEnableN;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign dqOut = memIf.rdData[DATA_W-1:0];
    assign parityLinesOut = memIf.rdData[PAR_LSB +: PAR_W];
    assign dqOe = s_q.drive;
    assign parityLinesOe = s_q.drive;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_load;
        !clockQualifierN && !loadOrAdvance;
    endsequence

    sequence s_selLoad;
        s_load ##0 (!selectLowFirstN && selectHighSecond && !selectLowThirdN);
    endsequence

    property p_addrCapture;
        @(posedge clk) disable iff (rst) s_selLoad |=> s_q.base == $past(addr) && s_q.active;
    endproperty
    a_addrCapture: assert property (p_addrCapture) else $error("address not captured");

    property p_seedLoad;
        @(posedge clk) disable iff (rst)
            s_load |=> s_q.seed == BURST_W'($past(addr) >> SEED_LSB) && s_q.beat == BEAT_RST;
    endproperty
    a_seedLoad: assert property (p_seedLoad) else $error("burst counter not seeded");

    property p_laneGate;
        @(posedge clk) disable iff (rst)
            s_selLoad ##0 !writeStrobeN |=> s_q.wrPend && s_q.wrLanes == ~$past(byteLaneWriteN);
    endproperty
    a_laneGate: assert property (p_laneGate) else $error("byte lanes not latched");

    property p_readNoWrite;
        @(posedge clk) disable iff (rst) s_load ##0 writeStrobeN |=> !s_q.wrPend && !memIf.wrEn;
    endproperty
    a_readNoWrite: assert property (p_readNoWrite) else $error("write without strobe");

    property p_advance;
        @(posedge clk) disable iff (rst)
            !clockQualifierN && loadOrAdvance && s_q.active |=> s_q.beat == 2'($past(s_q.beat) + 2'h1);
    endproperty
    a_advance: assert property (p_advance) else $error("burst counter not advanced");

    property p_stall;
        @(posedge clk) disable iff (rst)
            clockQualifierN |=> s_q == $past(s_q) && $stable(memIf.rdData);
    endproperty
    a_stall: assert property (p_stall) else $error("state moved while qualifier high");

    property p_deselect;
        @(posedge clk) disable iff (rst)
            s_load ##0 !(!selectLowFirstN && selectHighSecond && !selectLowThirdN) |=> !s_q.active;
    endproperty
    a_deselect: assert property (p_deselect) else $error("selected with wrong selects");

    property p_flowRead;
        @(posedge clk) disable iff (rst)
            s_selLoad ##0 (writeStrobeN && !outputEnableN && s_q.active) |=> dqOe && parityLinesOe;
    endproperty
    a_flowRead: assert property (p_flowRead) else $error("read data not driven");

    property p_release;
        @(posedge clk) disable iff (rst)
            s_load ##0 (!writeStrobeN || !s_q.active) |=> !dqOe && !parityLinesOe;
    endproperty
    a_release: assert property (p_release) else $error("lines driven when released");

    sequence s_adv;
        !clockQualifierN && loadOrAdvance && s_q.active;
    endsequence

    property p_linearOrder;
        @(posedge clk) disable iff (rst)
            s_adv ##0 burstLinear |->
            memIf.rdAddr == {s_q.base[ADDR_W-1:UPPER_LSB], BURST_W'(s_q.seed + s_q.beat + 2'h1)};
    endproperty
    a_linearOrder: assert property (p_linearOrder) else $error("linear beat address wrong");

    property p_interOrder;
        @(posedge clk) disable iff (rst)
            s_adv ##0 !burstLinear |->
            memIf.rdAddr == {s_q.base[ADDR_W-1:UPPER_LSB], s_q.seed ^ BURST_W'(s_q.beat + 2'h1)};
    endproperty
    a_interOrder: assert property (p_interOrder) else $error("interleaved beat address wrong");

    property p_maskPass;
        @(posedge clk) disable iff (rst)
            s_selLoad ##0 !writeStrobeN ##1 !clockQualifierN |->
            memIf.wrEn && memIf.wrMask == ~$past(byteLaneWriteN);
    endproperty
    a_maskPass: assert property (p_maskPass) else $error("write lanes not applied");

    property p_stallMem;
        @(posedge clk) disable iff (rst) clockQualifierN |-> !memIf.wrEn && !memIf.rdEn;
    endproperty
    a_stallMem: assert property (p_stallMem) else $error("storage touched on ignored edge");

    property p_writeRelease;
        @(posedge clk) disable iff (rst) !s_q.active || s_q.isWrite |-> !dqOe && !parityLinesOe;
    endproperty
    a_writeRelease: assert property (p_writeRelease) else $error("lines driven idle or writing");

    property p_oeMask;
        @(posedge clk) disable iff (rst)
            !clockQualifierN && outputEnableN |=> !dqOe && !parityLinesOe;
    endproperty
    a_oeMask: assert property (p_oeMask) else $error("lines driven with output enable off");

    property p_newAccess;
        @(posedge clk) disable iff (rst)
            s_load |=> s_q.isWrite == !$past(writeStrobeN) && s_q.base == $past(addr);
    endproperty
    a_newAccess: assert property (p_newAccess) else $error("new access not started");

    property p_readAddr;
        @(posedge clk) disable iff (rst)
            s_selLoad ##0 writeStrobeN |-> memIf.rdEn && memIf.rdAddr == addr;
    endproperty
    a_readAddr: assert property (p_readAddr) else $error("read not issued for loaded address");

endmodule

// *** verification/fsr_ctrl_model.sv ***
// fsr_ctrl_model: memory controller driving the sram input pins, one cycle per call
// assumes: clk from the bench; the bench resolves dq between this model and the device
`timescale 1ns/10ps
module fsr_ctrl_model
    import fsr_pkg::*;
(
    // clock
    input wire logic clk,
    // pins toward the device
    output logic [ADDR_W-1:0] addr = '0,
    output logic loadOrAdvance = 1'b0,
    output logic clockQualifierN = 1'b1,
    output logic writeStrobeN = 1'b1,
    output logic [LANES-1:0] byteLaneWriteN = 4'hf,
    output logic selectLowFirstN = 1'b1,
    output logic selectHighSecond = 1'b0,
    output logic selectLowThirdN = 1'b1,
    output logic outputEnableN = 1'b0,
    // word offered on dq and parity when the device is not driving
    output logic [WORD_W-1:0] wrWord = '0
);
    logic offQ = 1'b1;
    // output enable applied with the next cycle, set by the bench
    logic oeNextN = 1'b0;

    // ************************************************************
    // one bus cycle; sel 0 selects, 1..3 breaks one select each
    // ************************************************************
    task automatic cyc(input logic q, input logic adv, input logic wN,
        input logic [LANES-1:0] ln, input logic [ADDR_W-1:0] a, input logic [1:0] sel,
        input logic dv, input logic [WORD_W-1:0] d);
        logic ld;
        ld = !adv || offQ;
        @(posedge clk);
        if (!q && ld) begin
            offQ = (sel != 2'h0);
        end
        clockQualifierN <= q;
        loadOrAdvance <= !ld;
        writeStrobeN <= wN;
        byteLaneWriteN <= ln;
        addr <= a;
        selectLowFirstN <= (sel == 2'h1);
        selectHighSecond <= (sel != 2'h2);
        selectLowThirdN <= (sel == 2'h3);
        outputEnableN <= oeNextN;
        // released lines toggle, so a stale word can never match
        wrWord <= dv ? d : ~wrWord;
        #1;
    endtask
endmodule

// *** verification/testbench.sv ***
// testbench: scenario tasks for the sram input stage through the controller model
// assumes: design memory array not reset; checks are made 1 ns after each edge
`timescale 1ns/10ps
module testbench;
    import fsr_pkg::*;
    localparam logic [ADDR_W-1:0] BLK = 21'h012340;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic burstLinear = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic loadOrAdvance, clockQualifierN, writeStrobeN, outputEnableN;
    logic selectLowFirstN, selectHighSecond, selectLowThirdN;
    logic [LANES-1:0] byteLaneWriteN;
    logic [WORD_W-1:0] wrWord;
    logic [DATA_W-1:0] dqIn, dqOut;
    logic [PAR_W-1:0] parityLinesIn, parityLinesOut;
    logic dqOe, parityLinesOe;
    logic [WORD_W-1:0] exp [4];
    int miscompares = 0;
    int checksDone = 0;

    always #5 clk = ~clk;
    assign dqIn = dqOe ? dqOut : wrWord[DATA_W-1:0];
    assign parityLinesIn = parityLinesOe ? parityLinesOut : wrWord[WORD_W-1:PAR_LSB];

    fsr_ctrl_model ctrl (.clk, .addr, .loadOrAdvance, .clockQualifierN, .writeStrobeN,
        .byteLaneWriteN, .selectLowFirstN, .selectHighSecond, .selectLowThirdN,
        .outputEnableN, .wrWord);
    fsr_core dut (.clk, .rst, .addr, .loadOrAdvance, .clockQualifierN, .burstLinear,
        .writeStrobeN, .byteLaneWriteN, .selectLowFirstN, .selectHighSecond,
        .selectLowThirdN, .outputEnableN, .dqIn, .dqOut, .dqOe, .parityLinesIn,
        .parityLinesOut, .parityLinesOe);

    // ************************************************************
    // compares
    // ************************************************************
    task automatic chk(input string n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic oe(input logic e);
        chk("oe", {34'h0, e, e}, {34'h0, dqOe, parityLinesOe});
    endtask
    task automatic rd(input logic [WORD_W-1:0] e);
        oe(1'b1);
        chk("dq", e, {parityLinesOut, dqOut});
    endtask
    task automatic conclude();
        if (miscompares == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // write burst from seed 2, then read it back with no dead cycle
    task automatic s_burst();
        for (int i = 0; i < 4; i++) exp[i] = {4'(i), 32'hc0de0000 | 32'(i)};
        ctrl.cyc(0, 0, 0, 4'h0, BLK | 21'h2, 0, 0, '0);
        for (int i = 1; i < 4; i++) begin
            ctrl.cyc(0, 1, 0, 4'h0, '0, 0, 1, exp[(i + 1) % 4]);
            oe(1'b0);
        end
        ctrl.cyc(0, 0, 1, 4'h0, BLK | 21'h2, 0, 1, exp[1]);
        for (int i = 0; i < 4; i++) begin
            ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
            rd(exp[(i + 2) % 4]);
        end
    endtask
    // masked write with a stalled edge in its data phase, then a stalled read
    task automatic s_stall();
        ctrl.cyc(0, 0, 0, 4'ha, BLK | 21'h1, 0, 0, '0);
        ctrl.cyc(1, 0, 0, 4'h0, BLK, 0, 1, '0);
        ctrl.cyc(0, 0, 1, 4'h0, BLK | 21'h3, 0, 1, 36'hf_ffff_ffff);
        exp[1] = 36'h5_c0ff_00ff;
        for (int i = 0; i < 3; i++) begin
            ctrl.cyc(1, 0, 0, 4'h0, BLK, 1, 1, '0);
            rd(exp[3]);
        end
        ctrl.cyc(0, 0, 1, 4'h0, BLK | 21'h1, 0, 0, '0);
        ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
        rd(exp[1]);
        ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
        rd(exp[2]);
    endtask
    task automatic s_inter();
        @(posedge clk);
        burstLinear <= 1'b0;
        ctrl.cyc(0, 0, 1, 4'h0, BLK | 21'h1, 0, 0, '0);
        for (int i = 0; i < 4; i++) begin
            ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
            rd(exp[1 ^ i]);
        end
        @(posedge clk);
        burstLinear <= 1'b1;
    endtask
    // each select broken in turn, then the first access after deselect
    task automatic s_desel();
        for (int s = 1; s < 4; s++) begin
            ctrl.cyc(0, 0, 1, 4'h0, BLK, 2'(s), 0, '0);
            ctrl.cyc(0, 1, 1, 4'h0, '0, 2'(s), 0, '0);
            oe(1'b0);
        end
        ctrl.cyc(0, 0, 1, 4'h0, BLK | 21'h3, 0, 0, '0);
        ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
        oe(1'b0);
        ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
        rd(exp[0]);
        // output enable off for one edge releases the lines, then they return
        ctrl.oeNextN = 1'b1;
        ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
        rd(exp[1]);
        ctrl.oeNextN = 1'b0;
        ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
        oe(1'b0);
        ctrl.cyc(0, 1, 1, 4'h0, '0, 0, 0, '0);
        rd(exp[3]);
    endtask

    // ************************************************************
    // main sequence and hang guard
    // ************************************************************
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        oe(1'b0);
        chk("rst dq", 36'h0, {parityLinesOut, dqOut});
        s_burst();
        s_stall();
        s_inter();
        s_desel();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
